// ===== qup_modem.sv
// modem-side model: ring lines and serial rx pins of four channels
`default_nettype none
module qup_modem (
    input wire logic core_clk,
    input wire logic [3:0] ring_req,
    output logic [3:0] ring_in_n,
    output logic [3:0] serial_rx_in
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        ring_in_n = 4'hf;
        serial_rx_in = 4'h5;
    end
    // pins move on the falling edge, away from the design's sampling edge
    always @(negedge core_clk) begin
        ring_in_n <= ~ring_req;
        // rx pins toggle each cycle so a stale value never passes for loopback data
        serial_rx_in <= ~serial_rx_in;
    end
endmodule : qup_modem
`default_nettype wire

// ===== qup_params.svh
// constants and behaviour summary for the quad uart pin-signal block
// Behaviour
// - a low ring input means the modem reports an incoming ring.
// - a rising edge on a channel ring input raises that channel's ring interrupt.
// - with auto flow control bit 5 set, send request goes low when the transmitter has data waiting and the rx fifo is below threshold.
// - writing one to modem control bit 1 drives send request low.
// - after reset every send request output sits high.
// - tx data waiting and the rx fifo level only steer send request when auto flow control bit 5 is set.
// - the combined read/write strobe is used only in the 68-style bus mode.
// - strobe high with chip select reads the addressed register.
// - strobe low with chip select writes bus data to the addressed register.
// - in local loopback the rx pin is ignored and tx data feeds the receiver.
// - the shared rx ready is the wired-or of all four channel rx ready states.
// - shared rx ready goes low while any channel holds a character.
// - shared rx ready returns high once no characters remain anywhere.
// - each channel's rx ready state is readable through its own registers.
// - in 68-style mode the write strobe pin serves as the read/write strobe.
`ifndef QUP_PARAMS_SVH
`define QUP_PARAMS_SVH
`define QUP_NCH 4
`define QUP_ADDR_W 5
`define QUP_CH_LSB 3
`define QUP_REG_MODEM_CTL 3'h4
`define QUP_REG_STAT 3'h5
`define QUP_MODEM_CTL_SEND 1
`define QUP_MODEM_CTL_LOOP 4
`define QUP_MODEM_CTL_AUTO 5
`define QUP_STAT_RX_READY 0
`define QUP_STAT_RING 1
`define QUP_MODEM_CTL_RST 8'h00
`define QUP_RD_ZERO 8'h00
`define QUP_RING_IDLE 1'b1
`endif

// ===== qup_pkg.sv
// types for the quad uart pin-signal block
`default_nettype none
package qup_pkg;
    typedef struct packed {
        logic [7:0] modem_control_reg;
        logic ring_sync1;
        logic ring_sync2;
        logic ring_prev;
        logic ring_irq;
        logic [7:0] rdata;
    } qup_chan_t;
    typedef struct packed {
        logic cs_n;
        logic [4:0] addr;
        logic rw_strobe;
        logic [7:0] wdata;
    } qup_bus_t;
endpackage : qup_pkg
`default_nettype wire

// ===== qup_top.sv
// pin-signal logic of a four-channel uart: ring, send request, host strobe, loopback, rx ready
`include "qup_params.svh"
`default_nettype none
module qup_top (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic mode68,
    input wire qup_pkg::qup_bus_t bus,
    input wire logic [`QUP_NCH-1:0] ring_in_n,
    input wire logic [`QUP_NCH-1:0] serial_rx_in,
    input wire logic [`QUP_NCH-1:0] tx_serial,
    input wire logic [`QUP_NCH-1:0] tx_data_waiting,
    input wire logic [`QUP_NCH-1:0] rx_fifo_above_thresh,
    input wire logic [`QUP_NCH-1:0] chan_rx_ready,
    output logic [7:0] rd_data,
    output logic [`QUP_NCH-1:0] rx_to_receiver,
    output logic [`QUP_NCH-1:0] send_request_out,
    output logic [`QUP_NCH-1:0] ring_irq,
    output logic [`QUP_NCH-1:0] ring_clear_ack,
    output logic shared_rx_ready_n
);
    // ==========================================================
    // state
    typedef struct packed {
        qup_pkg::qup_chan_t [`QUP_NCH-1:0] ch;
        logic [7:0] rd;
    } qup_state_t;

    qup_state_t st;
    qup_state_t next_st;

    logic bus_sel;
    logic bus_wr;
    logic bus_rd;
    logic [1:0] ch_sel;
    logic [2:0] reg_sel;

    // ==========================================================
    // host strobe decode
    // the 68-style strobe rides on the write strobe pin; outside 68-style mode no access is decoded
    assign bus_sel = mode68 & ~bus.cs_n;
    assign bus_rd = bus_sel & bus.rw_strobe;
    assign bus_wr = bus_sel & ~bus.rw_strobe;
    assign ch_sel = bus.addr[`QUP_ADDR_W-1:`QUP_CH_LSB];
    assign reg_sel = bus.addr[`QUP_CH_LSB-1:0];

    // ==========================================================
    // next state
    always_comb begin
        next_st = st;
        for (int i = 0; i < `QUP_NCH; i++) begin
            next_st.ch[i].ring_sync1 = ring_in_n[i];
            // only the second stage feeds edge detection
            next_st.ch[i].ring_sync2 = st.ch[i].ring_sync1;
            next_st.ch[i].ring_prev = st.ch[i].ring_sync2;
            if (bus_wr && ch_sel == i[1:0] && reg_sel == `QUP_REG_MODEM_CTL) begin
                next_st.ch[i].modem_control_reg = bus.wdata;
            end
            // status read clears the ring flag, but a new edge in the same cycle wins
            if (bus_rd && ch_sel == i[1:0] && reg_sel == `QUP_REG_STAT) begin
                next_st.ch[i].ring_irq = 1'b0;
            end
            if (st.ch[i].ring_sync2 && !st.ch[i].ring_prev) begin
                next_st.ch[i].ring_irq = 1'b1;
            end
        end
        if (bus_rd) begin
            case (reg_sel)
                `QUP_REG_MODEM_CTL: next_st.rd = st.ch[ch_sel].modem_control_reg;
                `QUP_REG_STAT: begin
                    next_st.rd = `QUP_RD_ZERO;
                    next_st.rd[`QUP_STAT_RX_READY] = chan_rx_ready[ch_sel];
                    // low level on ring pin = ring present
                    next_st.rd[`QUP_STAT_RING] = ~st.ch[ch_sel].ring_sync2;
                end
                default: next_st.rd = `QUP_RD_ZERO;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            st <= '0;
            // sync chain resets to the idle pin level, so release gives no false edge
            for (int i = 0; i < `QUP_NCH; i++) begin
                st.ch[i].modem_control_reg <= `QUP_MODEM_CTL_RST;
                st.ch[i].ring_sync1 <= `QUP_RING_IDLE;
                st.ch[i].ring_sync2 <= `QUP_RING_IDLE;
                st.ch[i].ring_prev <= `QUP_RING_IDLE;
            end
        end else begin
            st <= next_st;
        end
    end

    // ==========================================================
    // outputs
    assign rd_data = st.rd;

    genvar g;
    generate
        for (g = 0; g < `QUP_NCH; g++) begin : g_ch
            logic auto_fc;
            assign auto_fc = st.ch[g].modem_control_reg[`QUP_MODEM_CTL_AUTO];
            // manual bit, or with auto flow, data waiting and fifo below threshold
            assign send_request_out[g] = ~(st.ch[g].modem_control_reg[`QUP_MODEM_CTL_SEND] |
                (auto_fc & tx_data_waiting[g] & ~rx_fifo_above_thresh[g]));
            assign rx_to_receiver[g] = st.ch[g].modem_control_reg[`QUP_MODEM_CTL_LOOP] ?
                tx_serial[g] : serial_rx_in[g];
            assign ring_irq[g] = st.ch[g].ring_irq;
            assign ring_clear_ack[g] = bus_rd && ch_sel == 2'(g) && reg_sel == `QUP_REG_STAT;
        end
    endgenerate

    assign shared_rx_ready_n = ~(|chan_rx_ready);

    // ==========================================================
    // checks
    rts_reset_a: assert property (@(posedge core_clk) disable iff (!resetn)
        $rose(resetn) |-> &send_request_out) else $error("rts not high after reset");
    rts_manual_a: assert property (@(posedge core_clk) disable iff (!resetn)
        (bus_wr && reg_sel == `QUP_REG_MODEM_CTL && bus.wdata[`QUP_MODEM_CTL_SEND]) |=>
        !send_request_out[$past(ch_sel)]) else $error("rts not low after write");
    rts_noauto_a: assert property (@(posedge core_clk) disable iff (!resetn)
        (!st.ch[0].modem_control_reg[`QUP_MODEM_CTL_AUTO] &&
        !st.ch[0].modem_control_reg[`QUP_MODEM_CTL_SEND]) |->
        send_request_out[0]) else $error("rts moved without auto flow");
    rts_auto_a: assert property (@(posedge core_clk) disable iff (!resetn)
        (st.ch[1].modem_control_reg[`QUP_MODEM_CTL_AUTO] && tx_data_waiting[1] &&
        !rx_fifo_above_thresh[1]) |-> !send_request_out[1])
        else $error("auto flow request not low");
    ring_edge_a: assert property (@(posedge core_clk) disable iff (!resetn)
        ($rose(ring_in_n[2]) && !ring_clear_ack[2]) ##1 !ring_clear_ack[2] ##1
        !ring_clear_ack[2] |=> ring_irq[2]) else $error("ring edge lost");
    ring_sync_a: assert property (@(posedge core_clk) disable iff (!resetn)
        $rose(ring_irq[2]) |-> $past(ring_in_n[2], 3) && !$past(ring_in_n[2], 4))
        else $error("ring flag without synced edge");
    ring_clear_a: assert property (@(posedge core_clk) disable iff (!resetn)
        (ring_clear_ack[2] && !(st.ch[2].ring_sync2 && !st.ch[2].ring_prev)) |=>
        !ring_irq[2]) else $error("ring flag not cleared");
    loop_sel_a: assert property (@(posedge core_clk) disable iff (!resetn)
        st.ch[0].modem_control_reg[`QUP_MODEM_CTL_LOOP] |-> rx_to_receiver[0] == tx_serial[0])
        else $error("loopback not isolating rx pin");
    loop_off_a: assert property (@(posedge core_clk) disable iff (!resetn)
        !st.ch[3].modem_control_reg[`QUP_MODEM_CTL_LOOP] |->
        rx_to_receiver[3] == serial_rx_in[3]) else $error("rx pin not passed");
    rd_other_a: assert property (@(posedge core_clk) disable iff (!resetn)
        (bus_rd && reg_sel != `QUP_REG_MODEM_CTL && reg_sel != `QUP_REG_STAT) |=>
        rd_data == `QUP_RD_ZERO) else $error("unused register not zero");
    shared_rx_ready_n_or_a: assert property (@(posedge core_clk) disable iff (!resetn)
        (chan_rx_ready != 4'h0) |-> !shared_rx_ready_n) else $error("rx ready not low");
    shared_rx_ready_n_idle_a: assert property (@(posedge core_clk) disable iff (!resetn)
        (chan_rx_ready == 4'h0) |-> shared_rx_ready_n) else $error("rx ready not high");
    write_gate_a: assert property (@(posedge core_clk) disable iff (!resetn)
        (!mode68 || bus.cs_n) |=> $stable(st.ch[2].modem_control_reg))
        else $error("write outside 68 mode");
    read_stat_a: assert property (@(posedge core_clk) disable iff (!resetn)
        (bus_rd && reg_sel == `QUP_REG_STAT) |=>
        rd_data[`QUP_STAT_RX_READY] == $past(chan_rx_ready[ch_sel]))
        else $error("bad status read");
endmodule : qup_top
`default_nettype wire

// ===== tb_top.sv
// self-checking bench for the quad uart pin-signal block
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 0, resetn = 0, mode68 = 1, shared_rx_ready_n;
    qup_pkg::qup_bus_t bus;
    logic [3:0] ring_req = 0, ring_in_n, serial_rx_in, tx_serial = 4'ha, txw = 0, thr = 0, crr = 0;
    logic [3:0] rx_to_receiver, send_request_out, ring_irq;
    logic [7:0] rd_data;
    int fail_count = 0, n_compared = 0;
    qup_top i_qup_top (.core_clk, .resetn, .mode68, .bus, .ring_in_n, .serial_rx_in,
        .tx_serial, .tx_data_waiting(txw), .rx_fifo_above_thresh(thr), .chan_rx_ready(crr),
        .rd_data, .rx_to_receiver, .send_request_out, .ring_irq, .ring_clear_ack(),
        .shared_rx_ready_n);
    qup_modem i_qup_modem (.core_clk, .ring_req, .ring_in_n, .serial_rx_in);
    // ==========
    // tasks
    task chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task acc(input logic rw, input logic [1:0] ch, input logic [2:0] rg, input logic [7:0] d);
        @(posedge core_clk) #1;
        bus = '{1'b0, {ch, rg}, rw, d};
        @(posedge core_clk) #1;
        bus.cs_n = 1'b1;
    endtask : acc
    task tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : tally_and_finish
    // ==========
    // tests
    initial forever #2 core_clk = ~core_clk;
    initial begin
        #4000;
        fail_count++;
        tally_and_finish;
    end
    initial begin
        bus = '0;
        bus.cs_n = 1'b1;
        repeat (2) @(posedge core_clk);
        #1 resetn = 1'b1;
        chk(send_request_out, 4'hf);
        chk(rd_data, 8'h00);
        mode68 = 0;
        acc(0, 2, 3'h4, 8'h02);
        mode68 = 1;
        chk(send_request_out, 4'hf);
        acc(0, 2, 3'h4, 8'h02);
        chk(send_request_out, 4'hb);
        acc(0, 2, 3'h3, 8'hff);
        chk(send_request_out, 4'hb);
        acc(1, 2, 3'h4, 8'h00);
        chk(rd_data, 8'h02);
        txw = 4'h3;
        acc(0, 1, 3'h4, 8'h20);
        chk(send_request_out, 4'h9);
        thr = 4'h2;
        #4 chk(send_request_out, 4'hb);
        acc(0, 0, 3'h4, 8'h10);
        chk(rx_to_receiver, {serial_rx_in[3:1], tx_serial[0]});
        #4 chk(rx_to_receiver, {serial_rx_in[3:1], tx_serial[0]});
        #4 chk({7'h0, shared_rx_ready_n}, 8'h01);
        crr = 4'h8;
        #4 chk({7'h0, shared_rx_ready_n}, 8'h00);
        acc(1, 3, 3'h5, 8'h00);
        chk(rd_data, 8'h01);
        chk(ring_irq, 4'h0);
        ring_req = 4'h4;
        repeat (6) @(posedge core_clk);
        acc(1, 2, 3'h5, 8'h00);
        chk(rd_data, 8'h02);
        chk(ring_irq, 4'h0);
        ring_req = 4'h0;
        repeat (6) @(posedge core_clk);
        #1 chk(ring_irq, 4'h4);
        acc(1, 2, 3'h5, 8'h00);
        #8 chk(ring_irq, 4'h0);
        tally_and_finish;
    end
endmodule : tb_top
`default_nettype wire
